// ### include/timer8_pkg.sv
// Package for the 8-bit timer compare-output block: register map,
// reset values, waveform mode codes, state and carrier types.
// Assumes a 32-bit APB master and a single system clock.
package timer8_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h24;
   localparam logic [7:0] CMPA_OFS   = 8'h28;
   localparam logic [7:0] CMPB_OFS   = 8'h2C;
   localparam logic [7:0] MODEHI_OFS = 8'h30;
   localparam logic [7:0] COUNT_OFS  = 8'h34;
   localparam logic [7:0] STAT_OFS   = 8'h38;
   localparam logic [7:0] CLR_OFS    = 8'h3C;
   localparam logic [7:0] IEN_OFS    = 8'h40;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int         COM_A_LSB   = 6;
   localparam int         COM_B_LSB   = 4;
   localparam int         WGM_LO_LSB  = 0;
   localparam logic [7:0] CTRL_WMASK  = 8'hF3;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] CMP_RST     = 8'h00;
   localparam logic [7:0] COUNT_RST   = 8'h00;
   localparam logic [7:0] MAX_VAL     = 8'hFF;
   localparam logic [7:0] BOTTOM_VAL  = 8'h00;
   localparam int         EV_MATCH_A  = 0;
   localparam int         EV_MATCH_B  = 1;
   localparam int         EV_OVF      = 2;
   localparam logic [2:0] EV_RST      = 3'h0;

   // ----------------------------------------------------------------
   // Waveform mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] WGM_NORMAL  = 3'h0;
   localparam logic [2:0] WGM_PC_FF   = 3'h1;
   localparam logic [2:0] WGM_CTC     = 3'h2;
   localparam logic [2:0] WGM_FAST_FF = 3'h3;
   localparam logic [2:0] WGM_PC_A    = 3'h5;
   localparam logic [2:0] WGM_FAST_A  = 3'h7;

   typedef enum logic [1:0] {
      DIR_UP   = 2'h1,
      DIR_DOWN = 2'h2
   } dir_e;

   typedef struct packed {
      logic o;
      logic oe;
   } pin_s;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  cmp_a;
      logic [7:0]  cmp_b;
      logic        wgm_hi;
      logic [7:0]  count;
      dir_e        dir;
      logic        oc_a;
      logic        oc_b;
      logic [2:0]  status;
      logic [2:0]  irq_en;
      logic        irq;
      pin_s        pin_a;
      pin_s        pin_b;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_s;

endpackage

// ### hw/timer8_compare_output_control.sv
// Compare-output control of an 8-bit timer with its counter, compare
// registers, mode decode, pin override and interrupt status.
// Assumes APB from the same clock; TIMER_TICK is a same-clock enable.
//
// Function
// - Synchronous on I/O clock, tick only enables.
// - Channel A mode nonzero overrides pin function; in PWM, mode 1 without the high bit keeps port data.
// - Channel B mode nonzero overrides pin function; in PWM, mode 1 keeps port data on the pin.
// - Non-PWM A: off, toggle, clear, set.
// - Fast PWM A: clear/set match, opposite BOTTOM.
// - PWM A mode 1 toggles only if high bit.
// - Fast PWM A, compare equals TOP: BOTTOM only.
// - Phase-correct A: up and down actions opposite.
// - Phase-correct A, compare equals TOP: act at TOP.
// - Non-PWM B: off, toggle, clear, set.
// - Fast PWM B like A; mode 1 reserved.
// - Phase-correct B like A; mode 1 reserved.
// - PWM B, compare equals TOP: ignore match.
// - Control bits 3:2 read zero, ignore writes.
// - Waveform mode select decodes six modes.
// - Fast PWM BOTTOM action on TOP-to-BOTTOM tick.
`timescale 1ns/1ns

module timer8_compare_output_control
   import timer8_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RESET,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output      logic [31:0] PRDATA,
   output      logic        PREADY,
   output      logic        PSLVERR,
   input  wire logic        TIMER_TICK,
   input  wire logic        PORT_A_OUT,
   input  wire logic        PORT_B_OUT,
   input  wire logic        DIR_A,
   input  wire logic        DIR_B,
   output      pin_s        PIN_A,
   output      pin_s        PIN_B,
   output      logic        IRQ
);

   // ----------------------------------------------------------------
   // Mode decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_fast(input logic [2:0] wgm);
      is_fast = (wgm == WGM_FAST_FF) || (wgm == WGM_FAST_A);
   endfunction

   function automatic logic is_pc(input logic [2:0] wgm);
      is_pc = (wgm == WGM_PC_FF) || (wgm == WGM_PC_A);
   endfunction

   function automatic logic [7:0] top_of(input logic [2:0] wgm, input logic [7:0] cmp_a);
      if ((wgm == WGM_CTC) || (wgm == WGM_PC_A) || (wgm == WGM_FAST_A)) begin
         top_of = cmp_a;
      end else begin
         top_of = MAX_VAL;
      end
   endfunction

   // Mode 1 in PWM is only usable where toggling is allowed
   function automatic logic connected(input logic [1:0] com, input logic [2:0] wgm, input logic tog_ok);
      if (com == 2'h0) begin
         connected = 1'b0;
      end else if ((is_fast(wgm) || is_pc(wgm)) && (com == 2'h1)) begin
         connected = tog_ok;
      end else begin
         connected = 1'b1;
      end
   endfunction

   // Next waveform level of one channel
   function automatic logic oc_step(
      input logic [1:0] com,
      input logic       oc,
      input logic [2:0] wgm,
      input logic       match,
      input logic       at_top,
      input logic       top_eq,
      input logic       up,
      input logic       tog_ok
   );
      logic r;
      r = oc;
      if (is_fast(wgm)) begin
         if (com == 2'h1) begin
            if (tog_ok && match) begin
               r = ~oc;
            end
         end else if (com[1]) begin
            if (at_top) begin
               r = ~com[0];
            end else if (match && !top_eq) begin
               r = com[0];
            end
         end
      end else if (is_pc(wgm)) begin
         if (com == 2'h1) begin
            if (tog_ok && match) begin
               r = ~oc;
            end
         end else if (com[1]) begin
            if (top_eq) begin
               // Level at TOP matches a down-count result so a full duty holds
               if (at_top) begin
                  r = ~com[0];
               end
            end else if (match) begin
               r = up ? com[0] : ~com[0];
            end
         end
      end else begin
         if (match) begin
            case (com)
               2'h1:    r = ~oc;
               2'h2:    r = 1'b0;
               2'h3:    r = 1'b1;
               default: r = oc;
            endcase
         end
      end
      oc_step = r;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   state_s     s_r;
   state_s     s_nxt;
   logic [2:0] wgm;
   logic [7:0] top;
   logic       setup;
   logic       wr;
   logic       match_a;
   logic       match_b;
   logic       at_top;
   logic       ovf;
   logic       up;
   logic [2:0] ev;
   logic [2:0] clr;

   assign wgm = {s_r.wgm_hi, s_r.ctrl[WGM_LO_LSB +: 2]};
   assign top = top_of(wgm, s_r.cmp_a);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt   = s_r;
      setup   = PSEL && !PENABLE;
      wr      = PSEL && PENABLE && s_r.pready && PWRITE;
      up      = (s_r.dir == DIR_UP);
      match_a = TIMER_TICK && (s_r.count == s_r.cmp_a);
      match_b = TIMER_TICK && (s_r.count == s_r.cmp_b);
      at_top  = TIMER_TICK && (s_r.count == top);
      clr     = EV_RST;

      // Bus: a zero-wait answer prepared in the setup cycle
      s_nxt.pready  = setup;
      s_nxt.pslverr = 1'b0;
      if (setup) begin
         s_nxt.prdata = 32'h0000_0000;
         case (PADDR)
            CTRL_OFS:   s_nxt.prdata[7:0] = s_r.ctrl & CTRL_WMASK;
            CMPA_OFS:   s_nxt.prdata[7:0] = s_r.cmp_a;
            CMPB_OFS:   s_nxt.prdata[7:0] = s_r.cmp_b;
            MODEHI_OFS: s_nxt.prdata[0]   = s_r.wgm_hi;
            COUNT_OFS:  s_nxt.prdata[7:0] = s_r.count;
            STAT_OFS:   s_nxt.prdata[2:0] = s_r.status;
            CLR_OFS:    s_nxt.prdata      = 32'h0000_0000;
            IEN_OFS:    s_nxt.prdata[2:0] = s_r.irq_en;
            default:    s_nxt.pslverr     = 1'b1;
         endcase
      end

      if (wr) begin
         case (PADDR)
            CTRL_OFS:   s_nxt.ctrl   = PWDATA[7:0] & CTRL_WMASK;
            CMPA_OFS:   s_nxt.cmp_a  = PWDATA[7:0];
            CMPB_OFS:   s_nxt.cmp_b  = PWDATA[7:0];
            MODEHI_OFS: s_nxt.wgm_hi = PWDATA[0];
            CLR_OFS:    clr          = PWDATA[2:0];
            IEN_OFS:    s_nxt.irq_en = PWDATA[2:0];
            default:    s_nxt.ctrl   = s_r.ctrl;
         endcase
      end

      // Counter: only moves on an enabled tick
      if (is_pc(wgm)) begin
         ovf = TIMER_TICK && (s_r.count == BOTTOM_VAL) && !up;
      end else begin
         ovf = at_top;
      end
      if (TIMER_TICK) begin
         if (is_pc(wgm)) begin
            if (up) begin
               if ((s_r.count >= top) && (top != BOTTOM_VAL)) begin
                  s_nxt.dir   = DIR_DOWN;
                  s_nxt.count = s_r.count - 8'h01;
               end else if (s_r.count < top) begin
                  s_nxt.count = s_r.count + 8'h01;
               end
            end else if (s_r.count == BOTTOM_VAL) begin
               s_nxt.dir   = DIR_UP;
               s_nxt.count = (top == BOTTOM_VAL) ? BOTTOM_VAL : 8'h01;
            end else begin
               s_nxt.count = s_r.count - 8'h01;
            end
         end else begin
            s_nxt.dir   = DIR_UP;
            s_nxt.count = at_top ? BOTTOM_VAL : s_r.count + 8'h01;
         end
      end

      // Waveform levels
      s_nxt.oc_a = oc_step(s_r.ctrl[COM_A_LSB +: 2], s_r.oc_a, wgm, match_a, at_top,
                           s_r.cmp_a == top, up, s_r.wgm_hi);
      s_nxt.oc_b = oc_step(s_r.ctrl[COM_B_LSB +: 2], s_r.oc_b, wgm, match_b, at_top,
                           s_r.cmp_b == top, up, 1'b0);

      // Pins: waveform replaces port data, driver follows direction
      s_nxt.pin_a.o  = connected(s_r.ctrl[COM_A_LSB +: 2], wgm, s_r.wgm_hi) ? s_nxt.oc_a
                                                                              : PORT_A_OUT;
      s_nxt.pin_a.oe = DIR_A;
      s_nxt.pin_b.o  = connected(s_r.ctrl[COM_B_LSB +: 2], wgm, 1'b0) ? s_nxt.oc_b
                                                                       : PORT_B_OUT;
      s_nxt.pin_b.oe = DIR_B;

      // Sticky events; a new event beats a simultaneous clear
      ev             = EV_RST;
      ev[EV_MATCH_A] = match_a;
      ev[EV_MATCH_B] = match_b;
      ev[EV_OVF]     = ovf;
      s_nxt.status   = (s_r.status & ~clr) | ev;
      s_nxt.irq      = |(s_nxt.status & s_nxt.irq_en);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         s_r.ctrl    <= CTRL_RST;
         s_r.cmp_a   <= CMP_RST;
         s_r.cmp_b   <= CMP_RST;
         s_r.wgm_hi  <= 1'b0;
         s_r.count   <= COUNT_RST;
         s_r.dir     <= DIR_UP;
         s_r.oc_a    <= 1'b0;
         s_r.oc_b    <= 1'b0;
         s_r.status  <= EV_RST;
         s_r.irq_en  <= EV_RST;
         s_r.irq     <= 1'b0;
         s_r.pin_a   <= '0;
         s_r.pin_b   <= '0;
         s_r.prdata  <= 32'h0000_0000;
         s_r.pready  <= 1'b0;
         s_r.pslverr <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign PRDATA  = s_r.prdata;
   assign PREADY  = s_r.pready;
   assign PSLVERR = s_r.pslverr;
   assign PIN_A   = s_r.pin_a;
   assign PIN_B   = s_r.pin_b;
   assign IRQ     = s_r.irq;

endmodule

// ### verification/timer8_asserts.sv
// Checker for the timer compare-output block, bound to its top module.
// Assumes one clock and zero-wait APB; shadows control from APB writes.
`timescale 1ns/1ns

module timer8_asserts
   import timer8_pkg::*;
(
   input wire logic        MCLK,
   input wire logic        RESET,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        TIMER_TICK,
   input wire logic        PORT_A_OUT,
   input wire logic        PORT_B_OUT,
   input wire logic        DIR_A,
   input wire logic        DIR_B,
   input wire pin_s        PIN_A,
   input wire pin_s        PIN_B
);
   logic [7:0] ctrl_m;
   logic       hi_m;
   logic       wr_ok;
   logic       rdc;
   logic       ka;
   logic       kb;

   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE;
   assign rdc   = PSEL && PENABLE && PREADY && !PWRITE && PADDR == CTRL_OFS;
   // Mode 1 stays off the pin in PWM unless channel A and the high bit
   assign ka = ctrl_m[7:6] != 2'h0 && !(ctrl_m[7:6] == 2'h1 && ctrl_m[0] && !hi_m);
   assign kb = ctrl_m[5:4] != 2'h0 && !(ctrl_m[5:4] == 2'h1 && ctrl_m[0]);

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ctrl_m <= 8'h00;
         hi_m   <= 1'b0;
      end else if (wr_ok && PADDR == CTRL_OFS) begin
         ctrl_m <= PWDATA[7:0] & 8'hF3;
      end else if (wr_ok && PADDR == MODEHI_OFS) begin
         hi_m <= PWDATA[0];
      end
   end

   default clocking @(posedge MCLK);
   endclocking
   default disable iff (RESET);

   // Pins leave their reset value at the first edge after release
   AST_OE_A: assert property (!$past(RESET) |=> PIN_A.oe == $past(DIR_A))
      else $error("pin A enable does not follow direction");
   AST_OE_B: assert property (!$past(RESET) |=> PIN_B.oe == $past(DIR_B))
      else $error("pin B enable does not follow direction");
   AST_DISC_A: assert property (!ka && !$past(RESET) |=> PIN_A.o == $past(PORT_A_OUT))
      else $error("pin A not showing port data");
   AST_DISC_B: assert property (!kb && !$past(RESET) |=> PIN_B.o == $past(PORT_B_OUT))
      else $error("pin B not showing port data");
   // The pin takes the new waveform level at the tick edge itself
   AST_QUIET_A: assert property (ka && $stable({ctrl_m, hi_m}) && !TIMER_TICK |=> $stable(PIN_A.o))
      else $error("pin A moved without a tick");
   AST_QUIET_B: assert property (kb && $stable({ctrl_m, hi_m}) && !TIMER_TICK |=> $stable(PIN_B.o))
      else $error("pin B moved without a tick");
   AST_RD_CTRL: assert property (rdc |-> PRDATA[7:0] == ctrl_m)
      else $error("control read back wrong");
   AST_RD_RSV: assert property (rdc |-> PRDATA[31:8] == 24'h0 && PRDATA[3:2] == 2'h0)
      else $error("control reserved bits not zero");
endmodule

bind timer8_compare_output_control timer8_asserts u_asserts (.MCLK, .RESET, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PRDATA, .PREADY, .TIMER_TICK, .PORT_A_OUT, .PORT_B_OUT, .DIR_A, .DIR_B, .PIN_A, .PIN_B);

// ### verification/pin_load.sv
// Load on one port pin driven by the block.
// Assumes a pull-up: a released line reads high, never the last value.
`timescale 1ns/1ns

module pin_load
   import timer8_pkg::*;
(
   input  wire pin_s p,
   output wire logic lvl
);
   assign lvl = p.oe ? p.o : 1'b1;
endmodule

// ### verification/timer8_compare_output_control_tb.sv
// Bench for the timer compare-output block: APB tasks and a cycle model.
// Assumes zero-wait APB and the pin loads of pin_load.
`timescale 1ns/1ns

module timer8_compare_output_control_tb
   import timer8_pkg::*;
;
   logic        MCLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic        TIMER_TICK = 0, PORT_A_OUT = 0, PORT_B_OUT = 0, DIR_A = 0, DIR_B = 0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic        PREADY, PSLVERR, IRQ, la, lb, se, mh, up, oa, ob, na, nb, tk = 0, fst = 0;
   logic [2:0]  st;
   pin_s        PIN_A, PIN_B, ea, eb;
   logic [7:0]  mc, ma, mb, cn;
   logic [15:0] cyc = 16'h0;
   int          mismatches = 0, tests_run = 0;
   logic [2:0]  md [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

   timer8_compare_output_control uut (.MCLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .TIMER_TICK, .PORT_A_OUT, .PORT_B_OUT, .DIR_A, .DIR_B, .PIN_A, .PIN_B, .IRQ);
   pin_load load_a (.p(PIN_A), .lvl(la));
   pin_load load_b (.p(PIN_B), .lvl(lb));

   // ----
   // Reference model
   // ----
   wire [2:0] wg = {mh, mc[1:0]};
   wire [7:0] tp = (wg == 3'h2 || wg == 3'h5 || wg == 3'h7) ? ma : 8'hFF;
   wire       ka = mc[7:6] != 2'h0 && !(mc[7:6] == 2'h1 && wg[0] && !mh);
   wire       kb = mc[5:4] != 2'h0 && !(mc[5:4] == 2'h1 && wg[0]);

   function automatic logic act(logic [1:0] c, logic o, logic [7:0] v, logic tg);
      logic m;
      m = cn == v;
      if (c == 2'h0) return o;
      if (!wg[0]) return !m ? o : c == 2'h1 ? !o : c[0];
      if (c == 2'h1) return m && tg ? !o : o;
      if (wg[1]) return cn == tp ? !c[0] : m ? c[0] : o;
      return !m ? o : (v == tp || !up) ? !c[0] : c[0];
   endfunction

   always @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         cn <= 8'h00; up <= 1'b1; oa <= 1'b0; ob <= 1'b0; ea <= 2'h0; eb <= 2'h0; st <= 3'h0;
      end else begin
         // Pin register takes the new waveform level at the same edge
         na = TIMER_TICK ? act(mc[7:6], oa, ma, mh) : oa;
         nb = TIMER_TICK ? act(mc[5:4], ob, mb, 1'b0) : ob;
         oa <= na;
         ob <= nb;
         ea <= {ka ? na : PORT_A_OUT, DIR_A};
         eb <= {kb ? nb : PORT_B_OUT, DIR_B};
         if (TIMER_TICK) begin
            st <= st | {((wg[0] && !wg[1]) ? (!up && cn == 8'h00) : (cn == tp)), cn == mb, cn == ma};
            if (wg[0] && !wg[1]) begin
               up <= up ? cn != tp : cn == 8'h00;
               cn <= (up ? cn != tp : cn == 8'h00) ? cn + 8'h01 : cn - 8'h01;
            end else cn <= cn == tp ? 8'h00 : cn + 8'h01;
         end
      end
   end

   always @(negedge MCLK) if (!RESET) chk("pins", {ea, eb, ea.oe ? ea.o : 1'b1, eb.oe ? eb.o : 1'b1},
      {PIN_A, PIN_B, la, lb});

   // ----
   // Clock, stimulus and tasks
   // ----
   initial forever #20 MCLK = ~MCLK;

   always @(posedge MCLK) begin
      cyc <= cyc + 16'h1;
      TIMER_TICK <= tk & (cyc[0] | fst);
      PORT_A_OUT <= cyc[2];
      PORT_B_OUT <= cyc[3];
      DIR_A <= ~&cyc[5:4];
      DIR_B <= ~&cyc[6:5];
      if (cyc == 16'h9C40) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Read compares against d; writes also update the model
   task automatic xf(logic w, logic [7:0] a, logic [31:0] d);
      PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge MCLK) PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      se = PSLVERR;
      if (!w) chk("prdata", d, PRDATA);
      if (w && a == CTRL_OFS) mc <= d[7:0] & 8'hF3;
      if (w && a == CMPA_OFS) ma <= d[7:0];
      if (w && a == CMPB_OFS) mb <= d[7:0];
      if (w && a == MODEHI_OFS) mh <= d[0];
      PSEL <= 1'b0; PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic pk(logic e);
      @(negedge MCLK) chk("irq", e, IRQ);
      @(posedge MCLK);
   endtask

   task automatic rst();
      RESET <= 1'b1; mc <= 8'h00; ma <= 8'h00; mb <= 8'h00; mh <= 1'b0;
      repeat (5) @(posedge MCLK);
      RESET <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      rst();
      xf(0, CTRL_OFS, 32'h0);
      xf(1, CTRL_OFS, 32'hFF);
      xf(0, CTRL_OFS, 32'hF3);
      xf(0, 8'h10, 32'h0);
      chk("slverr", 1, se);
      xf(1, CTRL_OFS, 32'h0);
      xf(1, CMPA_OFS, 32'h5);
      xf(1, CMPB_OFS, 32'h80);
      xf(1, IEN_OFS, 32'h1);
      fst <= 1'b1; tk <= 1'b1;
      repeat (20) @(posedge MCLK);
      tk <= 1'b0;
      repeat (3) @(posedge MCLK);
      xf(0, STAT_OFS, 32'h1);
      pk(1);
      xf(1, IEN_OFS, 32'h2);
      pk(0);
      xf(1, IEN_OFS, 32'h1);
      pk(1);
      xf(1, CLR_OFS, 32'h1);
      pk(0);
      xf(0, STAT_OFS, 32'h0);
      xf(0, CLR_OFS, 32'h0);
      // Every waveform mode with every output mode on both channels
      foreach (md[i]) begin
         for (int c = 0; c < 4; c++) begin
            rst();
            fst <= c[1];
            xf(1, CMPA_OFS, 32'h10);
            xf(1, CMPB_OFS, c[0] ? 32'hFF : 32'h10);
            xf(1, MODEHI_OFS, {31'h0, md[i][2]});
            xf(1, CTRL_OFS, {24'h0, c[1:0], ~c[1:0], 2'h3, md[i][1:0]});
            tk <= 1'b1;
            repeat (600) @(posedge MCLK);
            tk <= 1'b0;
            repeat (3) @(posedge MCLK);
            xf(0, STAT_OFS, {29'h0, st});
            xf(0, COUNT_OFS, {24'h0, cn});
         end
      end
      report_and_stop();
   end
endmodule
